// ==== cycle_timer.sv ====
// Purpose: Down counter that reports when a loaded number of cycles has elapsed
// Assumes: loadValue is nonzero
// Notes:   expired stays high until the next start
`timescale 1ns/1ps
`default_nettype none
module cycle_timer #(
  parameter int WIDTH = 23
) (
  input  wire logic             core_clk,
  input  wire logic             reset_n,
  input  wire logic             start,
  input  wire logic [WIDTH-1:0] loadValue,
  output var  logic             expired
);

  typedef struct packed {
    logic [WIDTH-1:0] count;
    logic             expired;
  } timer_state_type;

  timer_state_type state_reg;
  timer_state_type state_next;

  always_comb begin
    state_next = state_reg;
    if (start) begin
      state_next.count   = loadValue;
      state_next.expired = 1'b0;
    end else if (state_reg.count != '0) begin
      state_next.count = state_reg.count - WIDTH'(1);
      if (state_reg.count == WIDTH'(1)) begin
        state_next.expired = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign expired = state_reg.expired;

endmodule // cycle_timer
`default_nettype wire

// ==== host_model.sv ====
// Purpose: Host side model sending host commands and driving the powerdown pin
// Assumes: power_seq_pkg is compiled first
// Notes:   Outputs change 1 ns after the rising edge
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic                        core_clk,
  output var  power_seq_pkg::host_txn_type hostTxn,
  output var  logic                        powerdownPinN,
  output var  logic                        hostCsN
);
  import power_seq_pkg::*;
  initial begin
    hostTxn = '0;
    powerdownPinN = 1'b1;
    hostCsN = 1'b1;
  end
  // ==========================================================================
  // One-cycle command strobe
  task automatic send(input host_cmd_type op, input logic [7:0] arg);
    @(posedge core_clk);
    #1 hostTxn = '{1'b1, HOST_CMD_PREFIX, op, arg};
    @(posedge core_clk);
    #1 hostTxn.valid = 1'b0;
  endtask
  task automatic pin(input logic v, input int cycles);
    @(posedge core_clk);
    #1 powerdownPinN = v;
    repeat (cycles) @(posedge core_clk);
    #1;
  endtask
endmodule // host_model
`default_nettype wire

// ==== pin_state_ctrl.sv ====
// Purpose: Holds the programmable powerdown pin states and the pin control flags
// Assumes: Only the power-on reset clears the programmed states
// Notes:   Mode code 2'b11 is not a state and its writes are dropped
`timescale 1ns/1ps
`default_nettype none
module pin_state_ctrl
  import power_seq_pkg::*;
(
  input  wire logic                        core_clk,
  input  wire logic                        reset_n,
  input  wire logic                        write,
  input  wire logic [3:0]                  group,
  input  wire logic [1:0]                  mode,
  input  wire logic                        applyPd,
  input  wire logic                        holdLevels,
  output var  power_seq_pkg::pin_ctrl_type pinCtrl
);

  pin_ctrl_type state_reg;
  pin_ctrl_type state_next;

  always_comb begin
    state_next               = state_reg;
    state_next.applyPdStates = applyPd;
    state_next.holdLevels    = holdLevels;
    if (write && (32'(group) < PIN_GROUP_COUNT) && (mode != 2'b11)) begin
      state_next.modes[{group, 1'b0} +: 2] = mode;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      // Reset state is SLEEP, so levels are held from the start
      state_reg <= '{holdLevels: 1'b1, applyPdStates: 1'b0, modes: PIN_PD_DEFAULT};
    end else begin
      state_reg <= state_next;
    end
  end

  assign pinCtrl = state_reg;

endmodule // pin_state_ctrl
`default_nettype wire

// ==== power_seq_pkg.sv ====
// Purpose: Shared constants, enumerations and carriers of the power state and boot sequencer
// Assumes: core_clk at 200 MHz; host transactions arrive already decoded from the serial link
// Notes:   Command opcodes and the frequency code are local encodings
`default_nettype none
package power_seq_pkg;

  // ==========================================================================
  // Timing
  localparam int CORE_CLK_PERIOD_NS  = 5;
  localparam int PD_RESET_MIN_NS     = 5_000_000;
  localparam int CLK_SETTLE_NS       = 20_000_000;
  localparam int PD_RESET_MIN_CYCLES = (PD_RESET_MIN_NS + CORE_CLK_PERIOD_NS - 1) / CORE_CLK_PERIOD_NS;
  localparam int CLK_SETTLE_CYCLES   = (CLK_SETTLE_NS + CORE_CLK_PERIOD_NS - 1) / CORE_CLK_PERIOD_NS;
  localparam int TIMER_WIDTH         = 23;

  // ==========================================================================
  // Serial transaction prefixes
  localparam logic [1:0] MEM_READ_PREFIX  = 2'h0;
  localparam logic [1:0] HOST_CMD_PREFIX  = 2'h1;
  localparam logic [1:0] MEM_WRITE_PREFIX = 2'h2;

  typedef enum logic [7:0] {
    CMD_ACTIVE       = 8'h01,
    CMD_STANDBY      = 8'h02,
    CMD_SLEEP        = 8'h03,
    CMD_POWERDOWN    = 8'h04,
    CMD_RESET_PULSE  = 8'h05,
    CMD_CLK_INTERNAL = 8'h06,
    CMD_CLK_EXTERNAL = 8'h07,
    CMD_CLK_FREQ     = 8'h08,
    CMD_PD_PIN_MODES = 8'h09
  } host_cmd_type;

  // ==========================================================================
  // Engine reset control
  localparam int         ENG_RST_WIDTH     = 3;
  localparam int         ENG_RST_AUDIO_BIT = 2;
  localparam int         ENG_RST_TOUCH_BIT = 1;
  localparam int         ENG_RST_GFX_BIT   = 0;
  localparam logic [2:0] ENG_RST_DEFAULT   = 3'h2;
  localparam logic [2:0] ENG_RST_RELEASED  = 3'h0;
  localparam logic [7:0] FREQ_SEL_DEFAULT  = 8'h00;

  // ==========================================================================
  // Power states
  typedef enum logic [2:0] {
    PS_SLEEP     = 3'b000,
    PS_BOOT_CLK  = 3'b001,
    PS_BOOT_RAM  = 3'b010,
    PS_BOOT_CFG  = 3'b011,
    PS_ACTIVE    = 3'b100,
    PS_STANDBY   = 3'b101,
    PS_POWERDOWN = 3'b110,
    PS_RESET     = 3'b111
  } power_state_type;

  // ==========================================================================
  // Pin groups and powerdown modes
  typedef enum logic [1:0] {
    PIN_FLOAT     = 2'b00,
    PIN_PULL_LOW  = 2'b01,
    PIN_PULL_HIGH = 2'b10
  } pin_mode_type;

  localparam int PIN_GROUP_COUNT = 13;
  localparam int PIN_GRP_AUDIO = 0, PIN_GRP_PANEL_RST = 1, PIN_GRP_BACKLIGHT = 2, PIN_GRP_DATA_EN = 3;
  localparam int PIN_GRP_DISPLAY_ON = 4, PIN_GRP_SYNC = 5, PIN_GRP_PCLK = 6, PIN_GRP_COLOUR = 7;
  localparam int PIN_GRP_GPIO = 8, PIN_GRP_IRQ = 9, PIN_GRP_TOUCH_XY = 10, PIN_GRP_TOUCH_BUS = 11;
  localparam int PIN_GRP_HOST_SDO = 12;
  // Audio and display side groups (0 to 7) pull low, the rest float
  localparam logic [2*PIN_GROUP_COUNT-1:0] PIN_PD_DEFAULT = 26'h0005555;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic       valid;
    logic [1:0] prefix;
    logic [7:0] opcode;
    logic [7:0] arg;
  } host_txn_type;

  typedef struct packed {
    logic oscEnable;
    logic pllEnable;
    logic coreClkEnable;
    logic corePowerEnable;
  } clock_ctrl_type;

  typedef struct packed {
    logic                           holdLevels;
    logic                           applyPdStates;
    logic [2*PIN_GROUP_COUNT-1:0]   modes;
  } pin_ctrl_type;

endpackage
`default_nettype wire

// ==== power_state_and_boot_sequencer_test.sv ====
// Purpose: Self-checking bench of the power state and boot sequencer
// Assumes: Shortened settle and pin reset counts
// Notes:   Boot handshakes answered one cycle after each start pulse
`timescale 1ns/1ps
`default_nettype none
module power_state_and_boot_sequencer_test;
  import power_seq_pkg::*;
  logic           core_clk = 1'b0;
  logic           reset_n = 1'b0;
  logic           ramRepairDone = 1'b0, configDone = 1'b0;
  logic           powerdownPinN, hostCsN, externalClockSel, globalReset, ramRepairStart, configStart;
  logic           memAccessEnable, engineEnable, hostSerialFloat;
  logic [7:0]     clockFreqSel;
  logic [2:0]     engineResetCtrl;
  logic           engineResetWrite = 1'b0;
  logic [2:0]     engineResetWdata = 3'h0;
  host_txn_type   hostTxn;
  clock_ctrl_type clockCtrl;
  pin_ctrl_type   pinCtrl;
  power_state_type powerState;
  int mismatches = 0, checksDone = 0;
  always #2.5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    ramRepairDone <= #1 ramRepairStart;
    configDone <= #1 configStart;
  end
  host_model host (.core_clk, .hostTxn, .powerdownPinN, .hostCsN);
  power_state_sequencer #(.PD_RESET_CYCLES(20), .CLK_SETTLE_CYCLES(16)) DUT (.core_clk, .reset_n,
    .powerdownPinN, .hostCsN, .hostTxn, .ramRepairDone, .configDone, .engineResetWrite,
    .engineResetWdata, .clockCtrl, .externalClockSel, .clockFreqSel, .globalReset, .ramRepairStart,
    .configStart, .engineResetCtrl, .memAccessEnable, .engineEnable, .powerState, .pinCtrl, .hostSerialFloat);
  // ==========================================================================
  // Checking helpers
  task automatic giveVerdict();
    $display("checksDone %0d mismatches %0d", checksDone, mismatches);
    if (mismatches == 0 && checksDone > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checksDone++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wait_st(input power_state_type st);
    int n;
    for (n = 0; n < 200 && powerState !== st; n++) begin
      @(posedge core_clk);
      #1;
    end
    chk(powerState, st);
    if (n == 200) giveVerdict();
  endtask
  // Engine reset control write, taken in ACTIVE
  task automatic eng_write(input logic [2:0] v);
    @(posedge core_clk);
    #1 engineResetWrite = 1'b1;
    engineResetWdata = v;
    @(posedge core_clk);
    #1 engineResetWrite = 1'b0;
    chk(engineResetCtrl, v);
  endtask
  // ==========================================================================
  // Scenarios
  task automatic t_boot();
    host.send(CMD_CLK_FREQ, 8'h03);
    chk(clockFreqSel, 8'h03);
    host.send(CMD_RESET_PULSE, 8'h00);
    chk({powerState, globalReset, hostSerialFloat, clockFreqSel}, {PS_RESET, 2'b11, 8'h03});
    wait_st(PS_SLEEP);
    host.send(CMD_ACTIVE, 8'h00);
    chk({powerState, clockCtrl, engineResetCtrl}, {PS_BOOT_CLK, 4'hd, 3'h2});
    // Settle count of 16 is loaded on the ACTIVE edge and read one edge after it runs out
    repeat (16) @(posedge core_clk);
    #1 chk(powerState, PS_BOOT_CLK);
    @(posedge core_clk);
    #1 chk({powerState, ramRepairStart}, {PS_BOOT_RAM, 1'b1});
    wait_st(PS_ACTIVE);
    chk({clockCtrl, engineResetCtrl, memAccessEnable, engineEnable}, {4'hf, 3'h0, 2'b11});
    eng_write(3'h4);
    eng_write(3'h0);
  endtask
  task automatic t_standby_sleep();
    host.send(CMD_STANDBY, 8'h00);
    chk({powerState, clockCtrl, engineEnable, pinCtrl.holdLevels}, {PS_STANDBY, 4'hd, 2'b01});
    host.send(CMD_ACTIVE, 8'h00);
    chk({powerState, memAccessEnable}, {PS_ACTIVE, 1'b1});
    host.send(CMD_SLEEP, 8'h00);
    chk({powerState, clockCtrl, memAccessEnable}, {PS_SLEEP, 4'h1, 1'b0});
    host.send(CMD_ACTIVE, 8'h00);
    wait_st(PS_ACTIVE);
    host.send(CMD_RESET_PULSE, 8'h00);
    chk({powerState, globalReset, engineResetCtrl, clockFreqSel}, {PS_RESET, 1'b1, 3'h2, 8'h03});
    wait_st(PS_SLEEP);
    host.send(CMD_ACTIVE, 8'h00);
    wait_st(PS_ACTIVE);
  endtask
  task automatic t_powerdown();
    host.send(CMD_POWERDOWN, 8'h00);
    chk({powerState, clockCtrl, memAccessEnable, pinCtrl.applyPdStates}, {PS_POWERDOWN, 4'h0, 2'b01});
    host.send(CMD_PD_PIN_MODES, 8'h02);
    chk(pinCtrl.modes[1:0], PIN_PULL_HIGH);
    host.send(CMD_ACTIVE, 8'h00);
    chk(globalReset, 1'b1);
    wait_st(PS_ACTIVE);
    chk({pinCtrl.modes[1:0], clockFreqSel}, {PIN_PULL_HIGH, FREQ_SEL_DEFAULT});
  endtask
  task automatic t_pin();
    host.pin(1'b0, 3);
    host.pin(1'b1, 3);
    chk(powerState, PS_POWERDOWN);
    host.send(CMD_ACTIVE, 8'h00);
    wait_st(PS_ACTIVE);
    host.pin(1'b0, 22);
    host.pin(1'b1, 0);
    wait_st(PS_SLEEP);
    host.send(CMD_CLK_EXTERNAL, 8'h00);
    chk({globalReset, externalClockSel, hostSerialFloat}, 3'b111);
    wait_st(PS_SLEEP);
    host.send(CMD_CLK_INTERNAL, 8'h00);
    chk({globalReset, externalClockSel}, 2'b10);
  endtask
  initial begin
    repeat (4) @(posedge core_clk);
    #1 chk({powerState, clockCtrl, engineResetCtrl, hostSerialFloat}, {PS_SLEEP, 4'h1, 3'h2, 1'b1});
    chk(pinCtrl.modes, PIN_PD_DEFAULT);
    reset_n = 1'b1;
    t_boot();
    t_standby_sleep();
    t_powerdown();
    t_pin();
    giveVerdict();
  end
endmodule // power_state_and_boot_sequencer_test
`default_nettype wire

// ==== power_state_sequencer.sv ====
// Purpose: Power state machine, reset sources and boot sequence of the display controller core
// Assumes: Host transactions are decoded to one-cycle strobes; powerdownPinN is synchronous
// Notes:   Clock and power gating are requests to the analog and clock tree
`timescale 1ns/1ps
`default_nettype none
module power_state_sequencer #(
  parameter int PD_RESET_CYCLES   = power_seq_pkg::PD_RESET_MIN_CYCLES,
  parameter int CLK_SETTLE_CYCLES = power_seq_pkg::CLK_SETTLE_CYCLES
) (
  input  wire logic                           core_clk,
  input  wire logic                           reset_n,
  input  wire logic                           powerdownPinN,
  input  wire logic                           hostCsN,
  input  wire power_seq_pkg::host_txn_type    hostTxn,
  input  wire logic                           ramRepairDone,
  input  wire logic                           configDone,
  input  wire logic                           engineResetWrite,
  input  wire logic [2:0]                     engineResetWdata,
  output var  power_seq_pkg::clock_ctrl_type  clockCtrl,
  output var  logic                           externalClockSel,
  output var  logic [7:0]                     clockFreqSel,
  output var  logic                           globalReset,
  output var  logic                           ramRepairStart,
  output var  logic                           configStart,
  output var  logic [2:0]                     engineResetCtrl,
  output var  logic                           memAccessEnable,
  output var  logic                           engineEnable,
  output var  power_seq_pkg::power_state_type powerState,
  output var  power_seq_pkg::pin_ctrl_type    pinCtrl,
  output var  logic                           hostSerialFloat
);
  import power_seq_pkg::*;

  // ==========================================================================
  // State
  typedef struct packed {
    power_state_type fsm;
    logic            pinPrev;
    logic            pdByPin;
    logic            booted;
    logic            external_clock_cmd;
    logic [7:0]      freqSel;
    logic [2:0]      engRst;
    logic            globalReset;
    logic            ramStart;
    logic            cfgStart;
    logic            memEn;
    logic            engEn;
    clock_ctrl_type  clk;
    logic            serialFloat;
  } seq_state_type;

  seq_state_type state_reg;
  seq_state_type state_next;

  logic pinFall;
  logic pinRise;
  logic pdTimerExpired;
  logic bootTimerExpired;
  logic bootTimerStart;
  logic pinStateWrite;

  // Host command strobe of the given opcode
  function automatic logic isCmd(host_txn_type t, host_cmd_type op);
    return t.valid && (t.prefix == HOST_CMD_PREFIX) && (t.opcode == op);
  endfunction

  assign pinFall       = state_reg.pinPrev && !powerdownPinN;
  assign pinRise       = !state_reg.pinPrev && powerdownPinN;
  assign pinStateWrite = isCmd(hostTxn, CMD_PD_PIN_MODES);

  // ==========================================================================
  // Timers
  cycle_timer #(
    .WIDTH     (TIMER_WIDTH)
  ) pdLowTimer (
    .core_clk  (core_clk),
    .reset_n   (reset_n),
    .start     (pinFall),
    .loadValue (TIMER_WIDTH'(PD_RESET_CYCLES)),
    .expired   (pdTimerExpired)
  );

  cycle_timer #(
    .WIDTH     (TIMER_WIDTH)
  ) bootTimer (
    .core_clk  (core_clk),
    .reset_n   (reset_n),
    .start     (bootTimerStart),
    .loadValue (TIMER_WIDTH'(CLK_SETTLE_CYCLES)),
    .expired   (bootTimerExpired)
  );

  // ==========================================================================
  // Next state
  always_comb begin
    state_next             = state_reg;
    state_next.pinPrev     = powerdownPinN;
    state_next.globalReset = 1'b0;
    state_next.ramStart    = 1'b0;
    state_next.cfgStart    = 1'b0;
    bootTimerStart         = 1'b0;

    case (state_reg.fsm)
      PS_RESET: begin
        state_next.fsm = PS_SLEEP;
      end
      PS_SLEEP: begin
        if (isCmd(hostTxn, CMD_ACTIVE)) begin
          state_next.fsm = PS_BOOT_CLK;
          bootTimerStart = 1'b1;
        end else if (isCmd(hostTxn, CMD_CLK_FREQ)) begin
          state_next.freqSel = hostTxn.arg;
        end
      end
      PS_BOOT_CLK: begin
        // Oscillator and PLL settle before anything else runs
        if (bootTimerExpired) begin
          if (state_reg.booted) begin
            state_next.fsm = PS_ACTIVE;
          end else begin
            state_next.fsm      = PS_BOOT_RAM;
            state_next.ramStart = 1'b1;
          end
        end
      end
      PS_BOOT_RAM: begin
        if (ramRepairDone) begin
          state_next.fsm      = PS_BOOT_CFG;
          state_next.cfgStart = 1'b1;
        end
      end
      PS_BOOT_CFG: begin
        if (configDone) begin
          state_next.fsm    = PS_ACTIVE;
          state_next.booted = 1'b1;
          state_next.engRst = ENG_RST_RELEASED;
        end
      end
      PS_ACTIVE: begin
        if (isCmd(hostTxn, CMD_STANDBY)) begin
          state_next.fsm = PS_STANDBY;
        end else if (isCmd(hostTxn, CMD_SLEEP)) begin
          state_next.fsm = PS_SLEEP;
        end else if (isCmd(hostTxn, CMD_POWERDOWN)) begin
          state_next.fsm     = PS_POWERDOWN;
          state_next.pdByPin = 1'b0;
        end else if (engineResetWrite) begin
          state_next.engRst = engineResetWdata;
        end
      end
      PS_STANDBY: begin
        if (isCmd(hostTxn, CMD_ACTIVE)) begin
          state_next.fsm = PS_ACTIVE;
        end
      end
      PS_POWERDOWN: begin
        // An ACTIVE command with the pin high is the wake condition for both entry paths
        if (isCmd(hostTxn, CMD_ACTIVE) && powerdownPinN) begin
          state_next.fsm         = PS_BOOT_CLK;
          state_next.globalReset = 1'b1;
          state_next.booted      = 1'b0;
          state_next.pdByPin     = 1'b0;
          state_next.engRst      = ENG_RST_DEFAULT;
          state_next.external_clock_cmd      = 1'b0;
          state_next.freqSel     = FREQ_SEL_DEFAULT;
          bootTimerStart         = 1'b1;
        end
      end
      default: begin
        state_next.fsm = PS_RESET;
      end
    endcase

    // Software resets, ignored while the core is unpowered
    if (state_reg.fsm != PS_POWERDOWN) begin
      if (isCmd(hostTxn, CMD_RESET_PULSE) ||
          (isCmd(hostTxn, CMD_CLK_EXTERNAL) && !state_reg.external_clock_cmd) ||
          (isCmd(hostTxn, CMD_CLK_INTERNAL) && state_reg.external_clock_cmd)) begin
        state_next.fsm         = PS_RESET;
        state_next.globalReset = 1'b1;
        state_next.booted      = 1'b0;
        state_next.engRst      = ENG_RST_DEFAULT;
        state_next.ramStart    = 1'b0;
        state_next.cfgStart    = 1'b0;
        state_next.external_clock_cmd      = isCmd(hostTxn, CMD_CLK_EXTERNAL) ? 1'b1 :
                                 isCmd(hostTxn, CMD_CLK_INTERNAL) ? 1'b0 : state_reg.external_clock_cmd;
        bootTimerStart         = 1'b0;
      end
    end

    // Hardware pin: long low pulse resets the sequencer but not the pin modes, any low forces powerdown
    if (pinRise && pdTimerExpired) begin
      state_next.fsm         = PS_RESET;
      state_next.globalReset = 1'b1;
      state_next.booted      = 1'b0;
      state_next.pdByPin     = 1'b0;
      state_next.engRst      = ENG_RST_DEFAULT;
      state_next.external_clock_cmd      = 1'b0;
      state_next.freqSel     = FREQ_SEL_DEFAULT;
      state_next.ramStart    = 1'b0;
      state_next.cfgStart    = 1'b0;
      bootTimerStart         = 1'b0;
    end else if (!powerdownPinN) begin
      if (state_reg.fsm != PS_POWERDOWN) begin
        state_next.pdByPin = 1'b1;
      end
      state_next.fsm      = PS_POWERDOWN;
      state_next.ramStart = 1'b0;
      state_next.cfgStart = 1'b0;
      bootTimerStart      = 1'b0;
    end

    // Clock, power and access gating follow the next state
    state_next.clk.oscEnable       = (state_next.fsm inside {PS_BOOT_CLK, PS_BOOT_RAM, PS_BOOT_CFG,
                                                            PS_ACTIVE, PS_STANDBY});
    state_next.clk.pllEnable       = state_next.clk.oscEnable;
    state_next.clk.coreClkEnable   = (state_next.fsm == PS_ACTIVE);
    state_next.clk.corePowerEnable = (state_next.fsm != PS_POWERDOWN);
    state_next.memEn               = (state_next.fsm inside {PS_ACTIVE, PS_STANDBY});
    state_next.engEn               = (state_next.fsm == PS_ACTIVE);
    state_next.serialFloat         = (state_next.fsm == PS_RESET) && hostCsN;
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= '{fsm: PS_SLEEP, pinPrev: 1'b1, pdByPin: 1'b0, booted: 1'b0, external_clock_cmd: 1'b0,
                     freqSel: FREQ_SEL_DEFAULT, engRst: ENG_RST_DEFAULT, globalReset: 1'b0,
                     ramStart: 1'b0, cfgStart: 1'b0, memEn: 1'b0, engEn: 1'b0,
                     clk: '{oscEnable: 1'b0, pllEnable: 1'b0, coreClkEnable: 1'b0,
                            corePowerEnable: 1'b1},
                     serialFloat: 1'b1};
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================================================
  // Pin control
  pin_state_ctrl pinStates (
    .core_clk   (core_clk),
    .reset_n    (reset_n),
    .write      (pinStateWrite),
    .group      (hostTxn.arg[7:4]),
    .mode       (hostTxn.arg[1:0]),
    .applyPd    (state_next.fsm == PS_POWERDOWN),
    .holdLevels (state_next.fsm inside {PS_STANDBY, PS_SLEEP}),
    .pinCtrl    (pinCtrl)
  );

  // ==========================================================================
  // Outputs
  assign clockCtrl        = state_reg.clk;
  assign externalClockSel = state_reg.external_clock_cmd;
  assign clockFreqSel     = state_reg.freqSel;
  assign globalReset      = state_reg.globalReset;
  assign ramRepairStart   = state_reg.ramStart;
  assign configStart      = state_reg.cfgStart;
  assign engineResetCtrl  = state_reg.engRst;
  assign memAccessEnable  = state_reg.memEn;
  assign engineEnable     = state_reg.engEn;
  assign powerState       = state_reg.fsm;
  assign hostSerialFloat  = state_reg.serialFloat;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);

  a_reset_to_sleep: assert property (state_reg.fsm == PS_RESET |=> state_reg.fsm == PS_SLEEP)
    else $error("reset state did not settle in sleep");

  a_pin_forces_pd: assert property (!powerdownPinN && !(pinRise && pdTimerExpired)
                                    |=> state_reg.fsm == PS_POWERDOWN)
    else $error("low powerdown pin did not force powerdown");

  a_active_clocks: assert property (state_reg.fsm == PS_ACTIVE |-> clockCtrl.oscEnable &&
                                    clockCtrl.pllEnable && clockCtrl.coreClkEnable && engineEnable)
    else $error("active state without running clocks");

  a_standby_clocks: assert property (state_reg.fsm == PS_STANDBY |-> clockCtrl.oscEnable &&
                                     clockCtrl.pllEnable && !clockCtrl.coreClkEnable)
    else $error("standby clock gating wrong");

  a_sleep_clocks: assert property (state_reg.fsm == PS_SLEEP |-> !clockCtrl.oscEnable &&
                                   !clockCtrl.pllEnable && !clockCtrl.coreClkEnable)
    else $error("sleep clock gating wrong");

  a_pd_unpowered: assert property (state_reg.fsm == PS_POWERDOWN |-> !clockCtrl.corePowerEnable &&
                                   !clockCtrl.oscEnable && pinCtrl.applyPdStates)
    else $error("powerdown left core powered");

  a_pd_stays_low: assert property (state_reg.fsm == PS_POWERDOWN && !powerdownPinN
                                   |=> state_reg.fsm == PS_POWERDOWN)
    else $error("powerdown left while pin low");

  a_pd_exit_reset: assert property (state_reg.fsm == PS_POWERDOWN && powerdownPinN && state_reg.pinPrev &&
                                    isCmd(hostTxn, CMD_ACTIVE)
                                    |=> globalReset && state_reg.fsm == PS_BOOT_CLK &&
                                        engineResetCtrl == ENG_RST_DEFAULT)
    else $error("powerdown exit without global reset");

  a_standby_wake: assert property (state_reg.fsm == PS_STANDBY && powerdownPinN && state_reg.pinPrev &&
                                   isCmd(hostTxn, CMD_ACTIVE) |=> state_reg.fsm == PS_ACTIVE && memAccessEnable)
    else $error("standby wake not immediate");

  a_pin_long_reset: assert property (pinRise && pdTimerExpired |=> globalReset ##1 state_reg.fsm == PS_SLEEP)
    else $error("long powerdown pulse did not reset");

  a_reset_pulse: assert property (state_reg.fsm == PS_ACTIVE && powerdownPinN && state_reg.pinPrev &&
                                  isCmd(hostTxn, CMD_RESET_PULSE)
                                  |=> globalReset && state_reg.fsm == PS_RESET ##1 state_reg.fsm == PS_SLEEP)
    else $error("reset pulse command ignored");

  // A wake from SLEEP keeps the engine reset bits that software left behind
  a_boot_gated: assert property (state_reg.fsm inside {PS_BOOT_CLK, PS_BOOT_RAM, PS_BOOT_CFG}
                                 |-> (state_reg.booted || engineResetCtrl != ENG_RST_RELEASED) &&
                                     !clockCtrl.coreClkEnable)
    else $error("engines released during boot");

  a_settle_wait: assert property ($rose(state_reg.fsm == PS_BOOT_CLK) && !state_reg.booted && powerdownPinN
                                  |-> state_reg.fsm == PS_BOOT_CLK [*8])
    else $error("clock settle wait too short");

  a_mem_gate: assert property (state_reg.fsm inside {PS_SLEEP, PS_POWERDOWN} |-> !memAccessEnable)
    else $error("memory access open in low power");

  a_hold_levels: assert property (state_reg.fsm inside {PS_STANDBY, PS_SLEEP} |-> pinCtrl.holdLevels)
    else $error("pins not held in standby or sleep");

endmodule // power_state_sequencer
`default_nettype wire
